// File: hdl/tuner_pkg.sv
package tuner_pkg;
   // ****************************************
   // register indices (byte address = 4 x index)
   // ****************************************
   localparam logic [9:0] IDX_HOLDOFF = 10'h084;
   localparam logic [9:0] IDX_FREQ_A = 10'h085;
   localparam logic [9:0] IDX_FREQ_B = 10'h086;
   localparam logic [9:0] IDX_PHASE = 10'h087;
   localparam logic [9:0] IDX_CONTROL = 10'h088;
   localparam logic [9:0] IDX_STATUS = 10'h089;
   localparam logic [9:0] IDX_SCALE = 10'h092;
   localparam logic [9:0] IDX_EXPCFG = 10'h093;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CTL_BYPASS = 0;
   localparam int CTL_PDITHER = 1;
   localparam int CTL_ADITHER = 2;
   localparam int CTL_CLRHOP = 3;
   localparam int SCALE_QUIET_LSB = 5;
   localparam int SCALE_LOUD_LSB = 0;
   localparam int EXPCFG_INVERT = 0;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [4:0] EXP_BIAS = 5'h07;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;
   localparam int MANT_W = 14;
   localparam int OUT_W = 16;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic signed [13:0] mant_a;
      logic [2:0] exp_a;
      logic signed [13:0] mant_b;
      logic [2:0] exp_b;
      logic valid;
   } sample_in_t;
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
      logic valid;
   } iq_out_t;
   typedef struct packed {
      logic sleep;
      logic hop;
      logic start;
   } sync_ctl_t;
endpackage : tuner_pkg

// File: hdl/channel_tuner.sv
`timescale 1ns/1ps
`default_nettype none
module channel_tuner
   import tuner_pkg::*;
#(
   parameter int CHANNEL_INDEX = 0
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire sample_in_t sample_i,
   input wire logic level_indicator_i,
   input wire sync_ctl_t sync_i,
   output var iq_out_t iq_o,
   output logic [4:0] scale_value_o
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 7)
   begin : g_bad_channel
      $error("channel index must be 0 to 7");
   end

   // ****************************************
   // helpers
   // ****************************************
   // exponent driven arithmetic right shift, wraps mod 32
   function automatic logic signed [13:0] scale_mant(input logic signed [13:0] m,
      input logic [2:0] e, input logic [4:0] s, input logic inv);
      logic [4:0] sh;
      begin
         sh = inv ? 5'(EXP_BIAS - {2'b00, e} + s) : 5'({2'b00, e} + s);
         return m >>> sh;
      end
   endfunction : scale_mant

   // quarter wave sine, 17 points over 0..pi/2, point 0 in the low word
   localparam logic [271:0] QUARTER_TAB = {16'h7FFF,
      16'h7F61, 16'h7D89, 16'h7A7C, 16'h7641, 16'h70E2, 16'h6A6D, 16'h62F2, 16'h5A82,
      16'h5133, 16'h471C, 16'h3C56, 16'h30FB, 16'h2528, 16'h18F9, 16'h0C8C, 16'h0000};

   // sine of a 6-bit phase built from quarter wave symmetry
   function automatic logic signed [15:0] sine6(input logic [5:0] p);
      logic [4:0] k;
      logic signed [15:0] v;
      begin
         k = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
         v = $signed(QUARTER_TAB[{k, 4'h0} +: 16]);
         return p[5] ? -v : v;
      end
   endfunction : sine6

   // ****************************************
   // registers
   // ****************************************
   logic [15:0] holdoff_ff;
   logic [31:0] shadow_ff;
   logic [31:0] active_ff;
   logic [15:0] offset_ff;
   logic [3:0] ctrl_ff;
   logic [9:0] scale_ff;
   logic exp_inv_ff;
   logic [15:0] cnt_ff;
   logic counting_ff;
   logic sleep_prev_ff;
   logic [31:0] acc_ff;
   logic [15:0] lfsr_ff;
   logic signed [13:0] sa_ff;
   logic signed [13:0] sb_ff;
   logic [5:0] phase_ff;
   logic s1_valid_ff;
   logic [9:0] idx;
   logic wr_en;
   logic hop_event;
   logic transfer;
   logic [4:0] nxt_scale;
   logic [15:0] phase_dith;

   assign idx = paddr_i[11:2];
   assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

   // ****************************************
   // apb slave, one wait state
   // ****************************************
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else if (psel_i && penable_i && !pready_o)
      begin
         pready_o <= 1'b1;
         pslverr_o <= 1'b0;
         case (idx)
            IDX_HOLDOFF: prdata_o <= {16'h0000, holdoff_ff};
            IDX_FREQ_A: prdata_o <= {16'h0000, shadow_ff[15:0]};
            IDX_FREQ_B: prdata_o <= {16'h0000, shadow_ff[31:16]};
            IDX_PHASE: prdata_o <= {16'h0000, offset_ff};
            IDX_CONTROL: prdata_o <= {28'h0000000, ctrl_ff};
            IDX_STATUS: prdata_o <= {30'h00000000, level_indicator_i, counting_ff};
            IDX_SCALE: prdata_o <= {22'h000000, scale_ff};
            IDX_EXPCFG: prdata_o <= {31'h00000000, exp_inv_ff};
            default:
            begin
               prdata_o <= 32'h0000_0000;
               pslverr_o <= 1'b1;
            end
         endcase
      end
      else
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // register writes; frequency words land in the shadow
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         holdoff_ff <= REG_RESET;
         shadow_ff <= {REG_RESET, REG_RESET};
         offset_ff <= REG_RESET;
         ctrl_ff <= 4'h0;
         scale_ff <= 10'h000;
         exp_inv_ff <= 1'b0;
      end
      else if (wr_en)
      begin
         case (idx)
            IDX_HOLDOFF: holdoff_ff <= pwdata_i[15:0];
            IDX_FREQ_A: shadow_ff[15:0] <= pwdata_i[15:0];
            IDX_FREQ_B: shadow_ff[31:16] <= pwdata_i[15:0];
            IDX_PHASE: offset_ff <= pwdata_i[15:0];
            IDX_CONTROL: ctrl_ff <= pwdata_i[3:0];
            IDX_SCALE: scale_ff <= pwdata_i[9:0];
            IDX_EXPCFG: exp_inv_ff <= pwdata_i[EXPCFG_INVERT];
            default: ;
         endcase
      end
   end

   // ****************************************
   // shadow transfer and holdoff
   // ****************************************
   // sleep exit or hop
   assign hop_event = (sleep_prev_ff && !sync_i.sleep) || sync_i.hop;
   assign transfer = counting_ff && (cnt_ff == 16'h0001);

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         sleep_prev_ff <= 1'b0;
      else
         sleep_prev_ff <= sync_i.sleep;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cnt_ff <= 16'h0000;
         counting_ff <= 1'b0;
      end
      else if (hop_event)
      begin
         cnt_ff <= holdoff_ff;
         counting_ff <= (holdoff_ff != 16'h0000);
      end
      else if (counting_ff)
      begin
         cnt_ff <= 16'(cnt_ff - 16'h0001);
         counting_ff <= !transfer;
      end
   end

   // active frequency word
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         active_ff <= {REG_RESET, REG_RESET};
      else if (transfer)
         active_ff <= shadow_ff;
   end

   // ****************************************
   // oscillator
   // ****************************************
   // accumulator on this group's master clock
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         acc_ff <= 32'h0000_0000;
      else if (sync_i.start)
         acc_ff <= {offset_ff, 16'h0000};
      else if (transfer && ctrl_ff[CTL_CLRHOP])
         acc_ff <= {offset_ff, 16'h0000};
      else if (sample_i.valid)
         acc_ff <= 32'(acc_ff + active_ff);
   end

   // dither source
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         lfsr_ff <= LFSR_SEED;
      else
         lfsr_ff <= {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? LFSR_TAPS : 16'h0000);
   end

   assign phase_dith = ctrl_ff[CTL_PDITHER] ?
                       16'(acc_ff[31:16] + {6'h00, lfsr_ff[9:0]}) : acc_ff[31:16];

   // ****************************************
   // input scaling stage
   // ****************************************
   // field picked by level indicator
   assign nxt_scale = level_indicator_i ? scale_ff[SCALE_LOUD_LSB +: 5] :
                      scale_ff[SCALE_QUIET_LSB +: 5];

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sa_ff <= 14'sh0000;
         sb_ff <= 14'sh0000;
         phase_ff <= 6'h00;
         s1_valid_ff <= 1'b0;
         scale_value_o <= 5'h00;
      end
      else
      begin
         s1_valid_ff <= sample_i.valid;
         if (sample_i.valid)
         begin
            sa_ff <= scale_mant(sample_i.mant_a, sample_i.exp_a, nxt_scale, exp_inv_ff);
            sb_ff <= scale_mant(sample_i.mant_b, sample_i.exp_b, nxt_scale, exp_inv_ff);
            phase_ff <= phase_dith[15:10];
            scale_value_o <= nxt_scale;
         end
      end
   end

   // ****************************************
   // mixer stage
   // ****************************************
   logic signed [15:0] cos_v;
   logic signed [15:0] sin_v;
   logic signed [29:0] prod_i;
   logic signed [29:0] prod_q;

   assign cos_v = sine6(6'(phase_ff + 6'h10)) ^
                  {15'h0000, ctrl_ff[CTL_ADITHER] & lfsr_ff[11]};
   assign sin_v = sine6(phase_ff) ^ {15'h0000, ctrl_ff[CTL_ADITHER] & lfsr_ff[12]};
   assign prod_i = sa_ff * cos_v;
   assign prod_q = 30'(-(sa_ff * sin_v));

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         iq_o <= '0;
      end
      else
      begin
         iq_o.valid <= s1_valid_ff;
         if (s1_valid_ff)
         begin
            if (ctrl_ff[CTL_BYPASS])
            begin
               iq_o.i <= {sa_ff, 2'b00};
               iq_o.q <= {sb_ff, 2'b00};
            end
            else
            begin
               iq_o.i <= prod_i[28:13];
               iq_o.q <= prod_q[28:13];
            end
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   holdoff_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
      hop_event && holdoff_ff == 16'h0000 |=> !counting_ff ##1 !counting_ff)
      else $error("zero holdoff started a transfer");
   holdoff_xfer_a: assert property (@(posedge clock_i) disable iff (rst_i)
      counting_ff && cnt_ff == 16'h0001 && !hop_event |=> active_ff == $past(shadow_ff))
      else $error("shadow not moved at terminal count");
   shadow_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !transfer |=> active_ff == $past(active_ff))
      else $error("active word changed without transfer");
   start_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
      sync_i.start |=> acc_ff == {$past(offset_ff), 16'h0000})
      else $error("start sync did not load offset");
   acc_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
      sample_i.valid && !sync_i.start && !transfer
      |=> acc_ff == 32'($past(acc_ff) + $past(active_ff)))
      else $error("accumulator step wrong");
   bypass_path_a: assert property (@(posedge clock_i) disable iff (rst_i)
      s1_valid_ff && ctrl_ff[CTL_BYPASS] |=> iq_o.valid && iq_o.q == {$past(sb_ff), 2'b00})
      else $error("bypass did not route second input");
   scale_field_a: assert property (@(posedge clock_i) disable iff (rst_i)
      sample_i.valid && !level_indicator_i |=> scale_value_o == $past(scale_ff[9:5]))
      else $error("quiet field not used");
   exp_shift_a: assert property (@(posedge clock_i) disable iff (rst_i)
      sample_i.valid && !exp_inv_ff && nxt_scale == 5'h00
      |=> sa_ff == ($past(sample_i.mant_a) >>> $past(sample_i.exp_a)))
      else $error("plain exponent shift wrong");
   apb_wait_a: assert property (@(posedge clock_i) disable iff (rst_i)
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("apb answer late");
endmodule : channel_tuner
`default_nettype wire

// File: tb/gain_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module gain_adc_model
   import tuner_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [33:0] word_i,
   output var sample_in_t sample_o
);
   // ****************************************
   // converter output register
   // ****************************************
   // one strobed word per request; idle bus inverts the data bits again every cycle
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         sample_o <= '0;
      else if (go_i)
         sample_o <= {word_i, 1'b1};
      else
         sample_o <= {~sample_o[34:1], 1'b0};
   end
endmodule : gain_adc_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tuner_pkg::*;
   // ****************************************
   // stimulus and bookkeeping
   // ****************************************
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, li = 1'b0, go = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd, lfsr = 32'h3F4C0270;
   logic pready, pslverr, err;
   sync_ctl_t sync = '0;
   sample_in_t sample;
   iq_out_t iq;
   logic [4:0] scale_v;
   logic [33:0] word = '0;
   logic [36:0] notes[$];
   logic [36:0] note;
   logic [9:0] sc;
   logic [9:0] regs[7] = '{IDX_HOLDOFF, IDX_FREQ_A, IDX_FREQ_B, IDX_PHASE, IDX_CONTROL,
      IDX_SCALE, IDX_EXPCFG};
   int error_cnt = 0, tests_run = 0, cycles = 0;

   always #50 clock_i = ~clock_i;

   channel_tuner #(.CHANNEL_INDEX(0)) DUT (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sample_i(sample),
      .level_indicator_i(li), .sync_i(sync), .iq_o(iq), .scale_value_o(scale_v));

   gain_adc_model adc (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .word_i(word),
      .sample_o(sample));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
      return lfsr;
   endfunction : rnd

   task automatic check(input logic [38:0] got, input logic [38:0] want);
      tests_run++;
      if (got !== want)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {20'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1)
         @(posedge clock_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [9:0] idx, input logic [31:0] want, input logic werr);
      apb(1'b0, idx, 32'h0);
      check({6'h0, err, rd}, {6'h0, werr, want});
   endtask : rdchk

   task automatic pulse(input sync_ctl_t p);
      @(posedge clock_i);
      sync <= p;
      @(posedge clock_i);
      sync <= '0;
   endtask : pulse

   // one converter word; expectation from the shift law and the oscillator phase
   // mode 0 bypass, 1 mixer at phase zero, 2 mixer a quarter turn on
   task automatic send(input logic inv, input logic [2:0] ea, input logic [1:0] mode);
      logic [13:0] ma, mb;
      logic [2:0] eb;
      logic [4:0] s, sa, sb;
      logic lv;
      logic signed [13:0] xa, xb;
      logic signed [29:0] p, pn;
      ma = 14'(rnd());
      mb = 14'(rnd());
      eb = 3'(rnd());
      lv = rnd() > 32'h7FFFFFFF;
      s = lv ? sc[4:0] : sc[9:5];
      sa = inv ? 5'(5'h07 - 5'(ea) + s) : 5'(5'(ea) + s);
      sb = inv ? 5'(5'h07 - 5'(eb) + s) : 5'(5'(eb) + s);
      xa = 14'($signed(ma) >>> sa);
      xb = 14'($signed(mb) >>> sb);
      // full scale cosine at phase zero, full scale sine a quarter turn on
      p = xa * 30'sh7FFF;
      pn = -p;
      @(posedge clock_i);
      go <= 1'b1;
      li <= lv;
      word <= {ma, ea, mb, eb};
      case (mode)
         2'h0: notes.push_back({s, xa, 2'b00, xb, 2'b00});
         2'h1: notes.push_back({s, p[28:13], 16'h0000});
         default: notes.push_back({s, 16'h0000, pn[28:13]});
      endcase
      @(posedge clock_i);
      go <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask : send

   // ****************************************
   // output watcher and timeout
   // ****************************************
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         wrap_up();
      end
      else if (iq.valid === 1'b1)
      begin
         note = (notes.size() != 0) ? notes.pop_front() : '1;
         check({scale_v, iq.i, iq.q}, note);
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      foreach (regs[k])
         rdchk(regs[k], 32'h0, 1'b0);
      apb(1'b1, 10'h090, 32'hFFFF);
      rdchk(10'h090, 32'h0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         sc = 10'(rnd());
         apb(1'b1, regs[k], {22'h0, sc});
         rdchk(regs[k], {22'h0, sc}, 1'b0);
      end
      apb(1'b1, IDX_CONTROL, 32'h7);
      rdchk(IDX_CONTROL, 32'h7, 1'b0);
      // scale fields hold offset plus filter gain share
      sc = 10'(rnd());
      apb(1'b1, IDX_SCALE, {22'h0, sc});
      rdchk(IDX_SCALE, {22'h0, sc}, 1'b0);
      for (int inv = 0; inv < 2; inv++)
      begin
         // zero scale on the plain pass leaves the exponent as the whole shift
         sc = (inv == 0) ? 10'h000 : 10'(rnd());
         apb(1'b1, IDX_SCALE, {22'h0, sc});
         apb(1'b1, IDX_EXPCFG, 32'(inv));
         for (int e = 0; e < 8; e++)
            send(inv[0], 3'(e), 2'h0);
      end
      // tuner word written to shadow only; holdoff 0 keeps it there
      apb(1'b1, IDX_CONTROL, 32'h0);
      apb(1'b1, IDX_PHASE, 32'h0);
      apb(1'b1, IDX_FREQ_A, 32'h0);
      apb(1'b1, IDX_FREQ_B, 32'h4000);
      apb(1'b1, IDX_HOLDOFF, 32'h0);
      pulse(3'b001);
      pulse(3'b010);
      for (int n = 0; n < 4; n++)
         send(1'b1, 3'(rnd()), 2'h1);
      apb(1'b1, IDX_HOLDOFF, 32'h14);
      for (int ev = 0; ev < 2; ev++)
      begin
         pulse(ev == 0 ? 3'b010 : 3'b100);
         rdchk(IDX_STATUS, {30'h0, li, 1'b1}, 1'b0);
         repeat (25) @(posedge clock_i);
         rdchk(IDX_STATUS, {30'h0, li, 1'b0}, 1'b0);
      end
      // moved word is a quarter turn per sample; second sample sits on the sine peak
      sc = 10'h3FF;
      apb(1'b1, IDX_SCALE, {22'h0, sc});
      pulse(3'b001);
      send(1'b1, 3'h5, 2'h1);
      send(1'b1, 3'h5, 2'h2);
      repeat (5) @(posedge clock_i);
      check(39'(notes.size()), 39'h0);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
